// [tdso_pkg.sv]
// tdso_pkg: constants, register map and types of the trigger delay / strobe / exposure-end block
// assumes a 125 MHz system clock; nothing else
`default_nettype none

package tdso_pkg;

  // ==========================================================
  // clock and time base
  localparam int CLK_PERIOD_NS = 8;
  localparam int US_NS = 1000;
  localparam int CYC_PER_US = (US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TICK10_US = 10;

  // ==========================================================
  // trigger-to-exposure delay
  localparam int DLY_UNIT_US = 30;
  localparam int DLY_BASE_US = 122;
  localparam int LAT_STD_US = 120;
  localparam int LAT_A_US = 470;
  localparam int LAT_B_US = 1123;
  localparam int DLY_CNT_MIN = -4;
  localparam int DLY_CNT_MAX = 511;
  localparam int DLY_CNT_W = 10;
  localparam int DLY_US_W = 15;

  // ==========================================================
  // exposure-end pulse, in 10 us ticks
  localparam int SHT_DLY_MAX_US = 1000;
  localparam int SHT_W_MIN_US = 40;
  localparam int SHT_W_MAX_US = 10000;
  localparam int SHT_W_DEF_US = 5000;
  localparam int SHT_DLY_MAX_T = SHT_DLY_MAX_US / TICK10_US;
  localparam int SHT_W_MIN_T = SHT_W_MIN_US / TICK10_US;
  localparam int SHT_W_MAX_T = SHT_W_MAX_US / TICK10_US;
  localparam int SHT_W_DEF_T = SHT_W_DEF_US / TICK10_US;
  localparam int STB_W_DEF_T = 10;
  localparam int CNT_W = 16;

  // ==========================================================
  // register map (byte addresses)
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [2:0] RGN_CAM = 3'h1;
  localparam logic [2:0] RGN_FLASH = 3'h2;
  localparam logic [2:0] RGN_LINE = 3'h3;

  // ctrl fields
  localparam int CTRL_NOCAM_BIT = 0;
  localparam int CTRL_MULTI_BIT = 1;
  // camera delay register fields
  localparam int CAM_CNT_LSB = 0;
  localparam int CAM_TYPE_LSB = 12;
  localparam logic [1:0] CAM_TYPE_STD = 2'h0;
  localparam logic [1:0] CAM_TYPE_A = 2'h1;
  localparam logic [1:0] CAM_TYPE_B = 2'h2;
  // flash register fields
  localparam int FL_DLY_LSB = 0;
  localparam int FL_W_LSB = 16;
  // line register fields
  localparam int LN_DLY_LSB = 0;
  localparam int LN_DLY_W = 7;
  localparam int LN_W_LSB = 8;
  localparam int LN_W_W = 10;
  localparam int LN_POL_BIT = 20;
  localparam int LN_SEL_BIT = 21;
  localparam int LN_CAM_LSB = 24;
  // status fields
  localparam int ST_CAM_LSB = 0;
  localparam int ST_STB_LSB = 8;
  localparam int ST_LN_LSB = 16;

  // ==========================================================
  // timer phases, gray along idle -> wait -> active
  typedef enum logic [1:0] {
    TDSO_IDLE = 2'b00,
    TDSO_WAIT = 2'b01,
    TDSO_ACT = 2'b11
  } tdso_phase_t;

endpackage : tdso_pkg

`default_nettype wire

// [tdso_tick.sv]
// tdso_tick: free-running 1 us and 10 us tick generator
// assumes a synchronously released active-low reset
`default_nettype none
`timescale 1ns/10ps

module tdso_tick (
  input wire logic clk,
  input wire logic rst_n,
  output logic tick_us,
  output logic tick_10us
);

  logic [7:0] cyc_q;
  logic [3:0] us_q;

  // ==========================================================
  // cycle and microsecond counters
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cyc_q <= 8'h00;
      us_q <= 4'h0;
      tick_us <= 1'b0;
      tick_10us <= 1'b0;
    end else begin
      tick_us <= 1'b0;
      tick_10us <= 1'b0;
      if (cyc_q == 8'(tdso_pkg::CYC_PER_US - 1)) begin // RULE17
        cyc_q <= 8'h00;
        tick_us <= 1'b1;
        if (us_q == 4'(tdso_pkg::TICK10_US - 1)) begin
          us_q <= 4'h0;
          tick_10us <= 1'b1;
        end else begin
          us_q <= us_q + 4'h1;
        end
      end else begin
        cyc_q <= cyc_q + 8'h01;
      end
    end
  end

endmodule : tdso_tick

`default_nettype wire

// [tdso_core.sv]
// tdso_core: trigger-to-exposure delay, strobe and exposure-end outputs
// assumes pins trig_in, cam_present and cam_expo_done are asynchronous;
// register port is a plain one-cycle strobe bus on clk
`default_nettype none
`timescale 1ns/10ps

// Behaviour
// (RULE1) per-camera signed delay count, -4..511, 30us
// (RULE2) delay = count*30 + 122 + camera latency
// (RULE3) strobe or exposure-end, never both driven
// (RULE4) pulse on output when exposure ends
// (RULE5) exposure-end outputs indexed by line number
// (RULE6) strobe from flash settings, end from line
// (RULE7) one exposure-end pulse per captured image
// (RULE8) option drives strobes without attached camera
// (RULE9) option covers strobe outputs 0..7 or 0..3
// (RULE10) eight or four cameras per variant
// (RULE11) multi-line mode takes selection from line 0
// (RULE12) trigger source waits for strobe end
// (RULE13) exposure-end delay 0..1000us, 10us steps
// (RULE14) exposure-end width 40..10000us, default 5000us
// (RULE15) selectable exposure-end polarity, positive default
// (RULE16) strobe outputs follow physical connector numbers
// (RULE17) timing from 10us ticks, reset to idle; camera delay timers count 1us ticks
module tdso_core #(
  parameter int N_CAM = 8
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic trig_in,
  input wire logic [N_CAM-1:0] cam_present,
  input wire logic [N_CAM-1:0] cam_expo_done,
  output logic [N_CAM-1:0] cam_expose_start,
  output logic [N_CAM-1:0] strobe_trigger_out,
  output logic [N_CAM-1:0] exposure_end_out
);

  // ==========================================================
  // elaboration check
  if (N_CAM != 8 && N_CAM != 4) begin : g_bad_n_cam // RULE10
    $error("tdso_core: N_CAM must be 8 or 4");
  end

  // ==========================================================
  // functions
  function automatic logic [31:0] clamp_u(input logic [31:0] v, input int lo, input int hi);
    logic [31:0] r;
    r = v;
    if (v < 32'(lo)) begin
      r = 32'(lo);
    end else if (v > 32'(hi)) begin
      r = 32'(hi);
    end
    return r;
  endfunction : clamp_u

  function automatic logic [tdso_pkg::DLY_US_W-1:0] dly_us(
    input logic signed [tdso_pkg::DLY_CNT_W-1:0] cnt, input logic [1:0] typ);
    int lat;
    int t;
    lat = tdso_pkg::LAT_STD_US;
    if (typ == tdso_pkg::CAM_TYPE_A) begin
      lat = tdso_pkg::LAT_A_US;
    end else if (typ == tdso_pkg::CAM_TYPE_B) begin
      lat = tdso_pkg::LAT_B_US;
    end
    t = int'(cnt) * tdso_pkg::DLY_UNIT_US + tdso_pkg::DLY_BASE_US + lat; // RULE2
    return tdso_pkg::DLY_US_W'(t);
  endfunction : dly_us

  // ==========================================================
  // reset release and pin synchronisers
  logic [1:0] rst_sync_q;
  logic rst_n;
  logic [2:0] trig_sync_q;
  logic [N_CAM-1:0] pres_s1_q, pres_s2_q;
  logic [N_CAM-1:0] done_s1_q, done_s2_q, done_s3_q;
  logic trig_rise;
  logic [N_CAM-1:0] done_rise;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      trig_sync_q <= 3'h0;
      pres_s1_q <= '0;
      pres_s2_q <= '0;
      done_s1_q <= '0;
      done_s2_q <= '0;
      done_s3_q <= '0;
    end else begin
      trig_sync_q <= {trig_sync_q[1:0], trig_in};
      pres_s1_q <= cam_present;
      pres_s2_q <= pres_s1_q;
      done_s1_q <= cam_expo_done;
      done_s2_q <= done_s1_q;
      done_s3_q <= done_s2_q;
    end
  end
  assign trig_rise = trig_sync_q[1] & ~trig_sync_q[2];
  assign done_rise = done_s2_q & ~done_s3_q; // RULE7

  // ==========================================================
  // time base
  logic tick_us;
  logic tick_10us;

  tdso_tick u_tick (
    .clk(clk),
    .rst_n(rst_n),
    .tick_us(tick_us),
    .tick_10us(tick_10us)
  );

  // ==========================================================
  // register file
  logic nocam_q;
  logic multi_q;
  logic signed [tdso_pkg::DLY_CNT_W-1:0] cam_cnt_q [N_CAM];
  logic [1:0] cam_type_q [N_CAM];
  logic [tdso_pkg::CNT_W-1:0] fl_dly_q [N_CAM];
  logic [tdso_pkg::CNT_W-1:0] fl_w_q [N_CAM];
  logic [tdso_pkg::LN_DLY_W-1:0] ln_dly_q [N_CAM];
  logic [tdso_pkg::LN_W_W-1:0] ln_w_q [N_CAM];
  logic [N_CAM-1:0] ln_pol_q;
  logic [N_CAM-1:0] ln_sel_q;
  logic [2:0] ln_cam_q [N_CAM];
  logic [2:0] widx;
  logic [2:0] wrgn;
  logic signed [tdso_pkg::DLY_CNT_W-1:0] wcnt;

  assign widx = reg_addr[4:2];
  assign wrgn = reg_addr[7:5];
  assign wcnt = reg_wdata[tdso_pkg::CAM_CNT_LSB +: tdso_pkg::DLY_CNT_W];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      nocam_q <= 1'b0; // RULE8
      multi_q <= 1'b0;
      ln_pol_q <= '0; // RULE15
      ln_sel_q <= '0; // RULE3
      for (int i = 0; i < N_CAM; i++) begin
        cam_cnt_q[i] <= '0; // RULE1
        cam_type_q[i] <= tdso_pkg::CAM_TYPE_STD;
        fl_dly_q[i] <= '0;
        fl_w_q[i] <= tdso_pkg::CNT_W'(tdso_pkg::STB_W_DEF_T);
        ln_dly_q[i] <= '0; // RULE13
        ln_w_q[i] <= tdso_pkg::LN_W_W'(tdso_pkg::SHT_W_DEF_T); // RULE14
        ln_cam_q[i] <= 3'(i);
      end
    end else if (reg_wr) begin
      if (reg_addr == tdso_pkg::ADDR_CTRL) begin
        nocam_q <= reg_wdata[tdso_pkg::CTRL_NOCAM_BIT];
        multi_q <= reg_wdata[tdso_pkg::CTRL_MULTI_BIT];
      end else if (int'(widx) < N_CAM && reg_addr[1:0] == 2'b00) begin // RULE10
        case (wrgn)
          tdso_pkg::RGN_CAM: begin
            if (wcnt < tdso_pkg::DLY_CNT_W'(tdso_pkg::DLY_CNT_MIN)) begin
              cam_cnt_q[widx] <= tdso_pkg::DLY_CNT_W'(tdso_pkg::DLY_CNT_MIN); // RULE1
            end else if (wcnt > tdso_pkg::DLY_CNT_W'(tdso_pkg::DLY_CNT_MAX)) begin
              cam_cnt_q[widx] <= tdso_pkg::DLY_CNT_W'(tdso_pkg::DLY_CNT_MAX);
            end else begin
              cam_cnt_q[widx] <= wcnt;
            end
            cam_type_q[widx] <= reg_wdata[tdso_pkg::CAM_TYPE_LSB +: 2];
          end
          tdso_pkg::RGN_FLASH: begin
            fl_dly_q[widx] <= reg_wdata[tdso_pkg::FL_DLY_LSB +: tdso_pkg::CNT_W]; // RULE6
            fl_w_q[widx] <= reg_wdata[tdso_pkg::FL_W_LSB +: tdso_pkg::CNT_W];
          end
          tdso_pkg::RGN_LINE: begin
            ln_dly_q[widx] <= tdso_pkg::LN_DLY_W'(clamp_u(
              32'(reg_wdata[tdso_pkg::LN_DLY_LSB +: tdso_pkg::LN_DLY_W]), 0, tdso_pkg::SHT_DLY_MAX_T)); // RULE13
            ln_w_q[widx] <= tdso_pkg::LN_W_W'(clamp_u(
              32'(reg_wdata[tdso_pkg::LN_W_LSB +: tdso_pkg::LN_W_W]),
              tdso_pkg::SHT_W_MIN_T, tdso_pkg::SHT_W_MAX_T)); // RULE14
            ln_pol_q[widx] <= reg_wdata[tdso_pkg::LN_POL_BIT]; // RULE15
            ln_sel_q[widx] <= reg_wdata[tdso_pkg::LN_SEL_BIT];
            ln_cam_q[widx] <= reg_wdata[tdso_pkg::LN_CAM_LSB +: 3];
          end
          default: begin
          end
        endcase
      end
    end
  end

  // ==========================================================
  // trigger-to-exposure timers, one per camera
  tdso_pkg::tdso_phase_t cam_ph_q [N_CAM];
  logic [tdso_pkg::DLY_US_W-1:0] cam_tmr_q [N_CAM];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cam_expose_start <= '0;
      for (int i = 0; i < N_CAM; i++) begin
        cam_ph_q[i] <= tdso_pkg::TDSO_IDLE; // RULE17
        cam_tmr_q[i] <= '0;
      end
    end else begin
      cam_expose_start <= '0;
      for (int i = 0; i < N_CAM; i++) begin
        case (cam_ph_q[i])
          tdso_pkg::TDSO_IDLE: begin
            if (trig_rise && pres_s2_q[i]) begin // RULE12
              cam_tmr_q[i] <= dly_us(cam_cnt_q[i], cam_type_q[i]); // RULE2
              cam_ph_q[i] <= tdso_pkg::TDSO_WAIT;
            end
          end
          tdso_pkg::TDSO_WAIT: begin
            if (tick_us) begin
              if (cam_tmr_q[i] == '0) begin
                cam_expose_start[i] <= 1'b1; // RULE1
                cam_ph_q[i] <= tdso_pkg::TDSO_IDLE;
              end else begin
                cam_tmr_q[i] <= cam_tmr_q[i] - 1'b1;
              end
            end
          end
          default: begin
            cam_ph_q[i] <= tdso_pkg::TDSO_IDLE;
          end
        endcase
      end
    end
  end

  // ==========================================================
  // strobe timers, one per physical connector
  tdso_pkg::tdso_phase_t stb_ph_q [N_CAM];
  logic [tdso_pkg::CNT_W-1:0] stb_tmr_q [N_CAM];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < N_CAM; i++) begin
        stb_ph_q[i] <= tdso_pkg::TDSO_IDLE;
        stb_tmr_q[i] <= '0;
      end
    end else begin
      for (int i = 0; i < N_CAM; i++) begin // RULE16
        case (stb_ph_q[i])
          tdso_pkg::TDSO_IDLE: begin
            if (trig_rise && (pres_s2_q[i] || nocam_q) && fl_w_q[i] != '0) begin // RULE8 RULE9
              stb_tmr_q[i] <= fl_dly_q[i]; // RULE6
              stb_ph_q[i] <= tdso_pkg::TDSO_WAIT;
            end
          end
          tdso_pkg::TDSO_WAIT: begin
            if (tick_10us) begin // RULE17
              if (stb_tmr_q[i] == '0) begin
                stb_tmr_q[i] <= fl_w_q[i] - 1'b1;
                stb_ph_q[i] <= tdso_pkg::TDSO_ACT;
              end else begin
                stb_tmr_q[i] <= stb_tmr_q[i] - 1'b1;
              end
            end
          end
          tdso_pkg::TDSO_ACT: begin
            if (tick_10us) begin
              if (stb_tmr_q[i] == '0) begin
                stb_ph_q[i] <= tdso_pkg::TDSO_IDLE;
              end else begin
                stb_tmr_q[i] <= stb_tmr_q[i] - 1'b1;
              end
            end
          end
          default: begin
            stb_ph_q[i] <= tdso_pkg::TDSO_IDLE;
          end
        endcase
      end
    end
  end

  // ==========================================================
  // exposure-end timers, one per line
  tdso_pkg::tdso_phase_t ln_ph_q [N_CAM];
  logic [tdso_pkg::LN_W_W-1:0] ln_tmr_q [N_CAM];
  logic [N_CAM-1:0] ln_evt;

  always_comb begin
    for (int i = 0; i < N_CAM; i++) begin
      ln_evt[i] = (int'(ln_cam_q[i]) < N_CAM) ? done_rise[ln_cam_q[i]] : 1'b0; // RULE5
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < N_CAM; i++) begin
        ln_ph_q[i] <= tdso_pkg::TDSO_IDLE;
        ln_tmr_q[i] <= '0;
      end
    end else begin
      for (int i = 0; i < N_CAM; i++) begin
        case (ln_ph_q[i])
          tdso_pkg::TDSO_IDLE: begin
            if (ln_evt[i]) begin // RULE4 RULE7
              ln_tmr_q[i] <= tdso_pkg::LN_W_W'(ln_dly_q[i]); // RULE13
              ln_ph_q[i] <= tdso_pkg::TDSO_WAIT;
            end
          end
          tdso_pkg::TDSO_WAIT: begin
            if (ln_tmr_q[i] == '0) begin
              ln_tmr_q[i] <= ln_w_q[i] - 1'b1; // RULE14
              ln_ph_q[i] <= tdso_pkg::TDSO_ACT;
            end else if (tick_10us) begin
              ln_tmr_q[i] <= ln_tmr_q[i] - 1'b1;
            end
          end
          tdso_pkg::TDSO_ACT: begin
            if (tick_10us) begin
              if (ln_tmr_q[i] == '0) begin
                ln_ph_q[i] <= tdso_pkg::TDSO_IDLE;
              end else begin
                ln_tmr_q[i] <= ln_tmr_q[i] - 1'b1;
              end
            end
          end
          default: begin
            ln_ph_q[i] <= tdso_pkg::TDSO_IDLE;
          end
        endcase
      end
    end
  end

  // ==========================================================
  // shared output lines
  logic [N_CAM-1:0] sel_end;

  always_comb begin
    for (int i = 0; i < N_CAM; i++) begin
      sel_end[i] = multi_q ? ln_sel_q[0] : ln_sel_q[i]; // RULE11
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      strobe_trigger_out <= '0;
      exposure_end_out <= '0;
    end else begin
      for (int i = 0; i < N_CAM; i++) begin
        strobe_trigger_out[i] <= ~sel_end[i] & (stb_ph_q[i] == tdso_pkg::TDSO_ACT); // RULE3
        exposure_end_out[i] <= sel_end[i] & ((ln_ph_q[i] == tdso_pkg::TDSO_ACT) ^ ln_pol_q[i]); // RULE3 RULE15
      end
    end
  end

  // ==========================================================
  // read data, one cycle after the read strobe
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 32'h0000_0000;
    end else begin
      reg_rdata <= 32'h0000_0000;
      if (reg_rd) begin
        if (reg_addr == tdso_pkg::ADDR_CTRL) begin
          reg_rdata[tdso_pkg::CTRL_NOCAM_BIT] <= nocam_q;
          reg_rdata[tdso_pkg::CTRL_MULTI_BIT] <= multi_q;
        end else if (reg_addr == tdso_pkg::ADDR_STATUS) begin
          for (int i = 0; i < N_CAM; i++) begin
            reg_rdata[tdso_pkg::ST_CAM_LSB + i] <= cam_ph_q[i] != tdso_pkg::TDSO_IDLE;
            reg_rdata[tdso_pkg::ST_STB_LSB + i] <= stb_ph_q[i] != tdso_pkg::TDSO_IDLE;
            reg_rdata[tdso_pkg::ST_LN_LSB + i] <= ln_ph_q[i] != tdso_pkg::TDSO_IDLE;
          end
        end else if (int'(widx) < N_CAM && reg_addr[1:0] == 2'b00) begin
          case (wrgn)
            tdso_pkg::RGN_CAM: begin
              reg_rdata[tdso_pkg::CAM_CNT_LSB +: tdso_pkg::DLY_CNT_W] <= cam_cnt_q[widx];
              reg_rdata[tdso_pkg::CAM_TYPE_LSB +: 2] <= cam_type_q[widx];
            end
            tdso_pkg::RGN_FLASH: begin
              reg_rdata[tdso_pkg::FL_DLY_LSB +: tdso_pkg::CNT_W] <= fl_dly_q[widx];
              reg_rdata[tdso_pkg::FL_W_LSB +: tdso_pkg::CNT_W] <= fl_w_q[widx];
            end
            tdso_pkg::RGN_LINE: begin
              reg_rdata[tdso_pkg::LN_DLY_LSB +: tdso_pkg::LN_DLY_W] <= ln_dly_q[widx];
              reg_rdata[tdso_pkg::LN_W_LSB +: tdso_pkg::LN_W_W] <= ln_w_q[widx];
              reg_rdata[tdso_pkg::LN_POL_BIT] <= ln_pol_q[widx];
              reg_rdata[tdso_pkg::LN_SEL_BIT] <= ln_sel_q[widx];
              reg_rdata[tdso_pkg::LN_CAM_LSB +: 3] <= ln_cam_q[widx];
            end
            default: begin
            end
          endcase
        end
      end
    end
  end

endmodule : tdso_core

`default_nettype wire

// [tdso_core_monitor.sv]
// tdso_core_monitor: port-level checks of the trigger delay / strobe / exposure-end block
// assumes bind to tdso_core; trig_in is held low between triggers
`default_nettype none
`timescale 1ns/10ps

module tdso_core_monitor #(
  parameter int N_CAM = 8
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic trig_in,
  input wire logic [N_CAM-1:0] cam_present,
  input wire logic [N_CAM-1:0] cam_expo_done,
  input wire logic [N_CAM-1:0] cam_expose_start,
  input wire logic [N_CAM-1:0] strobe_trigger_out,
  input wire logic [N_CAM-1:0] exposure_end_out
);
  // ==========================================================
  // cycles since the last trigger edge
  localparam int MIN_EXP = 15125;
  logic trig_q;
  logic armed_q;
  logic [19:0] since_q;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      trig_q <= 1'b0;
      armed_q <= 1'b0;
      since_q <= 20'h00000;
    end else begin
      trig_q <= trig_in;
      if (trig_in && !trig_q) begin
        armed_q <= 1'b1;
        since_q <= 20'h00000;
      end else if (since_q != 20'hFFFFF) begin
        since_q <= since_q + 20'h00001;
      end
    end
  end

  // ==========================================================
  // assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  sequence s_quiet;
    (cam_expose_start == '0) && (strobe_trigger_out == '0) && (exposure_end_out == '0);
  endsequence
  chk_lane_exclusive: assert property ((strobe_trigger_out & exposure_end_out) == '0)
    else $error("strobe and exposure-end driven on one lane");
  chk_expose_late: assert property ((cam_expose_start != '0) |-> armed_q && (since_q >= MIN_EXP))
    else $error("exposure started too early");
  chk_expose_single: assert property ((cam_expose_start != '0) |=> ((cam_expose_start & $past(cam_expose_start)) == '0))
    else $error("exposure start longer than one cycle");
  chk_expose_present: assert property ((cam_expose_start & ~cam_present) == '0)
    else $error("exposure start for absent camera");
  chk_strobe_after_trig: assert property (((strobe_trigger_out & ~$past(strobe_trigger_out)) != '0)
    |-> armed_q && (since_q >= 20'h00002))
    else $error("strobe rose without trigger");
  chk_rdata_idle: assert property (!$past(reg_rd) |-> (reg_rdata == '0))
    else $error("read data outside read cycle");
  chk_reset_quiet: assert property ($rose(arst_n) |-> s_quiet [*2])
    else $error("outputs active right after reset");
  for (genvar i = 0; i < N_CAM; i++) begin : g_hold
    chk_end_hold: assert property ($changed(exposure_end_out[i]) |=> $stable(exposure_end_out[i]) [*8])
      else $error("exposure-end lane glitched");
  end
endmodule : tdso_core_monitor

bind tdso_core tdso_core_monitor #(.N_CAM(N_CAM)) u_tdso_core_monitor (.clk(clk), .arst_n(arst_n),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .trig_in(trig_in), .cam_present(cam_present), .cam_expo_done(cam_expo_done),
  .cam_expose_start(cam_expose_start), .strobe_trigger_out(strobe_trigger_out),
  .exposure_end_out(exposure_end_out));

`default_nettype wire

// [tdso_cam_model.sv]
// tdso_cam_model: cameras answering each exposure start with an exposure-done pulse
// assumes one clock shared with the block
`default_nettype none
`timescale 1ns/10ps

module tdso_cam_model #(
  parameter int N_CAM = 8,
  parameter int EXPO_CYC = 40
) (
  input wire logic clk,
  input wire logic [N_CAM-1:0] expose_start,
  output logic [N_CAM-1:0] expo_done
);
  // ==========================================================
  // one done pulse of 4 cycles per image
  int cnt [N_CAM] = '{default: 0};
  initial expo_done = '0;
  always @(posedge clk) begin
    for (int i = 0; i < N_CAM; i++) begin
      if (expose_start[i]) cnt[i] <= EXPO_CYC + 4;
      else if (cnt[i] != 0) cnt[i] <= cnt[i] - 1;
      expo_done[i] <= (cnt[i] != 0) && (cnt[i] <= 4);
    end
  end
endmodule : tdso_cam_model

`default_nettype wire

// [tb.sv]
// tb: register-driven tests of trigger delay, strobe and exposure-end timing
// assumes tdso_core with eight lanes, cameras on connectors 0 and 1
`default_nettype none
`timescale 1ns/10ps

module tb;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h00000000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic trig_in = 1'b0;
  logic [7:0] cam_present = 8'h03;
  logic [31:0] reg_rdata;
  logic [7:0] cam_expo_done;
  logic [7:0] cam_expose_start;
  logic [7:0] strobe_trigger_out;
  logic [7:0] exposure_end_out;
  int errors = 0;
  int n_compared = 0;
  int cyc = 0;
  int t0, t_x0, t_x1, t_e4, n_stb0, n_stb2, n_e1, n_e4, n_e5;
  logic [7:0] ra [5] = '{8'h00, 8'h24, 8'h44, 8'h68, 8'h10};
  logic [31:0] rv [5] = '{32'h00000000, 32'h00000000, 32'h000A0000, 32'h0201F400, 32'h00000000};

  always #4 clk = ~clk;

  tdso_core #(.N_CAM(8)) u_tdso_core (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .trig_in(trig_in),
    .cam_present(cam_present), .cam_expo_done(cam_expo_done), .cam_expose_start(cam_expose_start),
    .strobe_trigger_out(strobe_trigger_out), .exposure_end_out(exposure_end_out));
  tdso_cam_model #(.N_CAM(8), .EXPO_CYC(40)) u_tdso_cam_model (.clk(clk),
    .expose_start(cam_expose_start), .expo_done(cam_expo_done));

  // ==========================================================
  // event stamps and pulse lengths
  always @(posedge clk) begin
    cyc++;
    if (trig_in === 1'b1 && t0 < 0) t0 = cyc;
    if (cam_expose_start[0] === 1'b1 && t_x0 < 0) t_x0 = cyc;
    if (cam_expose_start[1] === 1'b1 && t_x1 < 0) t_x1 = cyc;
    if (exposure_end_out[4] === 1'b1 && t_e4 < 0) t_e4 = cyc;
    n_stb0 += int'(strobe_trigger_out[0] === 1'b1);
    n_stb2 += int'(strobe_trigger_out[2] === 1'b1);
    n_e1 += int'(exposure_end_out[1] === 1'b1);
    n_e4 += int'(exposure_end_out[4] === 1'b1);
    n_e5 += int'(exposure_end_out[5] === 1'b0);
  end

  // ==========================================================
  // bus and check tasks
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
    d = reg_rdata;
  endtask : rd

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic rng(input string nm, input int lo, input int hi, input int g);
    n_compared++;
    if (g < lo || g > hi) begin
      errors++;
      $display("wrong value %s expected %0d..%0d seen %0d", nm, lo, hi, g);
    end
  endtask : rng

  task automatic test_done;
    $display("errors %0d compared %0d", errors, n_compared);
    if (errors == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : test_done

  task automatic fire;
    logic [31:0] d;
    int idle;
    t0 = -1;
    t_x0 = -1;
    t_x1 = -1;
    t_e4 = -1;
    {n_stb0, n_stb2, n_e1, n_e4, n_e5} = '0;
    @(posedge clk);
    trig_in <= 1'b1;
    repeat (4) @(posedge clk);
    trig_in <= 1'b0;
    idle = 0;
    for (int k = 0; k < 400 && idle < 2; k++) begin
      repeat (100) @(posedge clk);
      rd(tdso_pkg::ADDR_STATUS, d);
      idle = (d[23:0] === 24'h000000) ? idle + 1 : 0;
    end
    if (idle < 2) begin
      errors++;
      $display("wrong value status expected idle seen %h", d);
      test_done;
    end
  endtask : fire

  // ==========================================================
  // main sequence
  initial begin
    logic [31:0] d;
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    for (int i = 0; i < 5; i++) begin
      rd(ra[i], d);
      chk("reset value", rv[i], d);
    end
    wr(8'h2C, 32'h000003FB);
    rd(8'h2C, d);
    chk("count low clamp", 32'h000003FC, d);
    wr(8'h2C, 32'h00000258);
    rd(8'h2C, d);
    chk("count wrap clamp", 32'h000003FC, d);
    wr(8'h2C, 32'h000001FF);
    rd(8'h2C, d);
    chk("count max", 32'h000001FF, d);
    wr(8'h20, 32'h000003FC);
    wr(8'h24, 32'h000003FD);
    wr(8'h40, 32'h00040002);
    wr(8'h48, 32'h00040002);
    wr(8'h60, 32'h00000400);
    wr(8'h64, 32'h01000400);
    wr(8'h70, 32'h00200403);
    wr(8'h74, 32'h01300400);
    repeat (4) @(posedge clk);
    chk("line 5 idle level", 32'h00000001, {31'h0, exposure_end_out[5]});
    fire;
    rng("camera 0 delay", 15250, 15390, t_x0 - t0);
    rng("camera 1 delay", 19000, 19140, t_x1 - t0);
    rng("strobe 0 width", 3750, 5002, n_stb0);
    rng("strobe 2 absent", 0, 0, n_stb2);
    rng("line 4 width", 3750, 5002, n_e4);
    rng("line 4 delay", 2540, 3810, t_e4 - t_x0);
    rng("line 5 low width", 3750, 5002, n_e5);
    wr(tdso_pkg::ADDR_CTRL, 32'h00000001);
    fire;
    rng("strobe 2 width", 3750, 5002, n_stb2);
    wr(8'h60, 32'h00200400);
    wr(tdso_pkg::ADDR_CTRL, 32'h00000003);
    fire;
    rng("strobe 0 in multi", 0, 0, n_stb0);
    rng("line 1 width", 3750, 5002, n_e1);
    test_done;
  end
endmodule : tb

`default_nettype wire
